// ### hdl/strc_consts.vh
// Constants for the target receive command block
`ifndef STRC_CONSTS_VH
`define STRC_CONSTS_VH

// ********************
// Register byte offsets
// ********************
`define STRC_OFS_CMD 8'h00
`define STRC_OFS_BASE 8'h04
`define STRC_OFS_CUR 8'h08
`define STRC_OFS_TRANSFER_MODE_REG 8'h0C
`define STRC_OFS_TOUT 8'h10
`define STRC_OFS_EXTENDED_MODE_REG 8'h14
`define STRC_OFS_STAT 8'h18
`define STRC_OFS_INT 8'h1C
`define STRC_OFS_EXTENDED_STATUS_REG 8'h20
`define STRC_OFS_DATA 8'h24
`define STRC_OFS_LINK 8'h28
`define STRC_OFS_BRK 8'h2C

// ********************
// Opcode layout
// ********************
`define STRC_OP_FIX_MASK 8'h39
`define STRC_OP_FIX_VAL 8'h28
`define STRC_OP_CPAR_BIT 8
`define STRC_PH_DOUT 2'h0
`define STRC_PH_CMD 2'h1
`define STRC_PH_BAD 2'h2
`define STRC_PH_MOUT 2'h3
`define STRC_COUNT_ONE 24'h00_0001

// ********************
// Link status and interrupt causes
// ********************
`define STRC_LINK_DISC 2'h0
`define STRC_LINK_INIT 2'h1
`define STRC_LINK_TGT 2'h2
`define STRC_INT_NONE 8'h00
`define STRC_INT_NORMAL 8'h01
`define STRC_INT_INVALID 8'h02
`define STRC_INT_OVUN 8'h03
`define STRC_INT_OFFSET 8'h04
`define STRC_INT_SPAR 8'h05
`define STRC_INT_CPAR 8'h06
`define STRC_INT_TOUT 8'h07
`define STRC_INT_RESET 8'h08
`define STRC_INT_BREAK 8'h09

// ********************
// Fields, codes and timing
// ********************
`define STRC_EXEC_CODE 8'h51
`define STRC_BIT_PARITY_CONTINUE_ENABLE 0
`define STRC_PHASE_WAIT 4'h8
`define STRC_RESP_OKAY 2'h0
`define STRC_RESP_SLVERR 2'h2

`endif

// ### hdl/strc_receive.v
// Target-side information reception command engine with AXI4-Lite registers
`timescale 1ns/100ps
`include "strc_consts.vh"

module strc_receive #(
	parameter FIFO_AW = 3
) (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// AXI4-Lite write channels
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read channels
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// SCSI bus pins, controls active low on the wire, data and parity taken active high
	input wire [7:0] scsi_db_i,
	input wire scsi_dbp_i,
	input wire scsi_ack_n_i,
	input wire scsi_rst_n_i,
	output reg scsi_req_n,
	output reg scsi_io_n,
	output reg scsi_msg_n,
	output reg scsi_cd_n,
	// DMA side
	input wire dma_ack,
	output reg dma_req,
	output reg [7:0] dma_data,
	output reg transfer_end_strobe,
	// Interrupt request
	output reg int_req
);

	localparam [FIFO_AW:0] DEPTH = {1'b1, {FIFO_AW{1'b0}}};
	localparam [3:0] S_IDLE = 4'h1;
	localparam [3:0] S_WAIT = 4'h2;
	localparam [3:0] S_XFER = 4'h4;
	localparam [3:0] S_DRAIN = 4'h8;
	localparam [1:0] HS_IDLE = 2'h0;
	localparam [1:0] HS_LOW = 2'h1;
	localparam [1:0] HS_HIGH = 2'h2;

	// ********************
	// Functions
	// ********************
	// Current counter load from selector pattern
	function [23:0] strc_load;
		input [1:0] sel;
		input [23:0] base;
		begin
			case (sel)
				2'h0: strc_load = base;
				2'h1: strc_load = {base[23:8], 8'h00};
				2'h2: strc_load = {16'h0000, base[7:0]};
				default: strc_load = `STRC_COUNT_ONE;
			endcase
		end
	endfunction

	// Byte-lane merge of a write
	function [31:0] strc_merge;
		input [31:0] old;
		input [31:0] data;
		input [3:0] strb;
		integer i;
		begin
			strc_merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i])
					strc_merge[i*8 +: 8] = data[i*8 +: 8];
			end
		end
	endfunction

	// ********************
	// Registers and wires
	// ********************
	reg [10:0] sync1_r;
	reg [10:0] sync2_r;
	reg ack_d_r;
	reg [3:0] state_r;
	reg [1:0] hs_r;
	reg [3:0] wait_r;
	reg [23:0] count_r;
	reg [23:0] base_r;
	reg [7:0] transfer_mode_reg_r;
	reg [15:0] tout_r;
	reg [7:0] extended_mode_reg_r;
	reg [1:0] link_r;
	reg [8:0] cmd_r;
	reg [1:0] extended_status_reg_r;
	reg [7:0] int_code_r;
	reg [7:0] int_next_r;
	reg rst_pend_r;
	reg eop_pend_r;
	reg [3:0] outst_r;
	reg [15:0] tmo_r;
	reg [7:0] fifo_mem [0:DEPTH-1];
	reg [FIFO_AW-1:0] wptr_r;
	reg [FIFO_AW-1:0] rptr_r;
	reg [FIFO_AW:0] fcnt_r;
	reg end_now;
	reg end_eop;
	reg [7:0] end_code;

	// Synchronised pins: rst, ack, parity, data
	wire rst_s = sync2_r[10];
	wire ack_s = sync2_r[9];
	wire [8:0] byte_s = sync2_r[8:0];
	wire ack_fall = ack_d_r & ~ack_s;
	wire ack_rise = ~ack_d_r & ack_s;
	wire busy = ~state_r[0];
	wire sync_mode = transfer_mode_reg_r[7:4] != 4'h0;
	wire fifo_full = fcnt_r == DEPTH;
	wire fifo_empty = fcnt_r == {(FIFO_AW+1){1'b0}};
	wire [7:0] occ = {{(7-FIFO_AW){1'b0}}, fcnt_r} + {4'h0, outst_r};
	wire room = occ < {{(7-FIFO_AW){1'b0}}, DEPTH};

	// AXI strobes
	wire wr_go = s_axi_awready & s_axi_awvalid & s_axi_wvalid;
	wire rd_go = s_axi_arready & s_axi_arvalid;
	wire [31:0] wval = s_axi_wdata;
	wire [31:0] base_wr = strc_merge({8'h00, base_r}, wval, s_axi_wstrb);
	wire [31:0] tout_wr = strc_merge({16'h0000, tout_r}, wval, s_axi_wstrb);
	wire wr_cmd = wr_go & (s_axi_awaddr == `STRC_OFS_CMD) & s_axi_wstrb[0];
	wire wr_int = wr_go & (s_axi_awaddr == `STRC_OFS_INT);
	wire wr_brk = wr_go & (s_axi_awaddr == `STRC_OFS_BRK) & s_axi_wstrb[0] & wval[0];
	wire rd_data = rd_go & (s_axi_araddr == `STRC_OFS_DATA);

	// Byte movement
	wire push = state_r[2] & (sync_mode ? ack_fall : (hs_r == HS_LOW) & ~ack_s);
	wire cpu_pop = rd_data & ~fifo_empty;
	wire dma_pop = dma_ack & ~fifo_empty & ~cpu_pop;
	wire pop = cpu_pop | dma_pop;
	wire spar_err = push & ~(^byte_s);
	wire ovun_err = busy & ((push & fifo_full) | (rd_data & fifo_empty));
	wire off_err = state_r[2] & sync_mode & ack_fall & (outst_r == 4'h0);
	wire waiting = state_r[2] & (sync_mode ? outst_r != 4'h0 : hs_r != HS_IDLE);
	wire tout_err = waiting & (tout_r != 16'h0000) & (tmo_r >= tout_r);
	wire req_rise = sync_mode & ~scsi_req_n;
	wire [3:0] inc = {3'h0, state_r[2] & req_rise};
	wire [3:0] dec = {3'h0, ack_fall & (outst_r != 4'h0)};
	wire bus_done = (count_r == 24'h00_0000) &
		(sync_mode ? (outst_r == 4'h0) & scsi_req_n : hs_r == HS_IDLE);

	// ********************
	// Pin synchronisers
	// ********************
	// Two flops on every SCSI input
	always @(posedge aclk) begin
		if (!aresetn) begin
			sync1_r <= 11'h7FF;
			sync2_r <= 11'h7FF;
			ack_d_r <= 1'b1;
		end else begin
			sync1_r <= {scsi_rst_n_i, scsi_ack_n_i, scsi_dbp_i, scsi_db_i};
			sync2_r <= sync1_r;
			ack_d_r <= sync2_r[9];
		end
	end

	// ********************
	// Termination decode
	// ********************
	// Abort priority: break, reset, then errors
	always @* begin
		end_now = busy;
		end_eop = 1'b1;
		end_code = `STRC_INT_NONE;
		if (wr_brk)
			end_code = `STRC_INT_BREAK;
		else if (!rst_s)
			end_code = `STRC_INT_RESET;
		else if (ovun_err)
			end_code = `STRC_INT_OVUN;
		else if (off_err)
			end_code = `STRC_INT_OFFSET;
		else if (spar_err && !extended_mode_reg_r[`STRC_BIT_PARITY_CONTINUE_ENABLE])
			end_code = `STRC_INT_SPAR;
		else if (tout_err)
			end_code = `STRC_INT_TOUT;
		else if (state_r[3] && fifo_empty)
			end_code = `STRC_INT_NORMAL;
		else
			end_now = 1'b0;
		if (end_code == `STRC_INT_RESET || end_code == `STRC_INT_NORMAL)
			end_eop = 1'b0;
	end

	// ********************
	// Command engine
	// ********************
	// Sequencer, registers, FIFO and interrupt cause
	always @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= S_IDLE;
			hs_r <= HS_IDLE;
			wait_r <= 4'h0;
			count_r <= 24'h00_0000;
			base_r <= 24'h00_0000;
			transfer_mode_reg_r <= 8'h00;
			tout_r <= 16'h0000;
			extended_mode_reg_r <= 8'h00;
			link_r <= `STRC_LINK_DISC;
			cmd_r <= 9'h000;
			extended_status_reg_r <= 2'h0;
			int_code_r <= `STRC_INT_NONE;
			int_next_r <= `STRC_INT_NONE;
			int_req <= 1'b0;
			rst_pend_r <= 1'b0;
			eop_pend_r <= 1'b0;
			outst_r <= 4'h0;
			tmo_r <= 16'h0000;
			wptr_r <= {FIFO_AW{1'b0}};
			rptr_r <= {FIFO_AW{1'b0}};
			fcnt_r <= {(FIFO_AW+1){1'b0}};
			scsi_req_n <= 1'b1;
			scsi_io_n <= 1'b1;
			scsi_msg_n <= 1'b1;
			scsi_cd_n <= 1'b1;
			dma_req <= 1'b0;
			dma_data <= 8'h00;
			transfer_end_strobe <= 1'b0;
		end else begin
			// Plain register writes
			if (wr_go && s_axi_awaddr == `STRC_OFS_BASE)
				base_r <= base_wr[23:0];
			if (wr_go && s_axi_awaddr == `STRC_OFS_TRANSFER_MODE_REG && s_axi_wstrb[0])
				transfer_mode_reg_r <= wval[7:0];
			if (wr_go && s_axi_awaddr == `STRC_OFS_TOUT)
				tout_r <= tout_wr[15:0];
			if (wr_go && s_axi_awaddr == `STRC_OFS_EXTENDED_MODE_REG && s_axi_wstrb[0])
				extended_mode_reg_r <= wval[7:0];
			if (wr_go && s_axi_awaddr == `STRC_OFS_LINK && s_axi_wstrb[0] && !busy)
				link_r <= wval[1:0];
			// Interrupt clear: second queued cause moves up
			if (wr_int) begin
				int_code_r <= int_next_r;
				int_next_r <= `STRC_INT_NONE;
				int_req <= int_next_r != `STRC_INT_NONE;
			end
			// Reset condition latch, set wins over clear
			if (!busy && !rst_s)
				rst_pend_r <= 1'b1;
			// FIFO
			if (push && !fifo_full) begin
				fifo_mem[wptr_r] <= byte_s[7:0];
				wptr_r <= wptr_r + {{(FIFO_AW-1){1'b0}}, 1'b1};
			end
			if (pop)
				rptr_r <= rptr_r + {{(FIFO_AW-1){1'b0}}, 1'b1};
			if ((push && !fifo_full) && !pop)
				fcnt_r <= fcnt_r + {{FIFO_AW{1'b0}}, 1'b1};
			else if (pop && !(push && !fifo_full))
				fcnt_r <= fcnt_r - {{FIFO_AW{1'b0}}, 1'b1};
			if (dma_pop)
				dma_data <= fifo_mem[rptr_r];
			dma_req <= busy & ~fifo_empty & ~pop;
			// End strobe in the next DMA service period
			transfer_end_strobe <= eop_pend_r & dma_ack;
			if (eop_pend_r && dma_ack)
				eop_pend_r <= 1'b0;
			if (spar_err)
				extended_status_reg_r[0] <= 1'b1;
			// Handshake stall timer
			tmo_r <= (waiting && !ack_fall && !ack_rise) ? tmo_r + 16'h0001 : 16'h0000;
			outst_r <= outst_r + inc - dec;
			case (state_r)
				S_IDLE: begin
					scsi_req_n <= 1'b1;
					if (wr_cmd) begin
						cmd_r <= wval[8:0];
						int_req <= 1'b1;
						if (rst_pend_r || !rst_s) begin
							int_code_r <= `STRC_INT_RESET;
							int_next_r <= `STRC_INT_INVALID;
							rst_pend_r <= ~rst_s;
							link_r <= `STRC_LINK_TGT;
						end else if (link_r != `STRC_LINK_TGT) begin
							int_code_r <= `STRC_INT_INVALID;
							link_r <= `STRC_LINK_TGT;
						end else if (~^wval[`STRC_OP_CPAR_BIT:0]) begin
							int_code_r <= `STRC_INT_CPAR;
							extended_status_reg_r[1] <= 1'b1;
							if (!extended_mode_reg_r[`STRC_BIT_PARITY_CONTINUE_ENABLE])
								eop_pend_r <= 1'b1;
						end else if ((wval[7:0] & `STRC_OP_FIX_MASK) != `STRC_OP_FIX_VAL ||
							wval[2:1] == `STRC_PH_BAD) begin
							int_code_r <= `STRC_INT_INVALID;
						end else begin
							int_req <= 1'b0;
							count_r <= strc_load(wval[7:6], base_r);
							extended_status_reg_r <= 2'h0;
							scsi_io_n <= 1'b1;
							scsi_msg_n <= wval[2:1] != `STRC_PH_MOUT;
							scsi_cd_n <= wval[2:1] == `STRC_PH_DOUT;
							wait_r <= `STRC_PHASE_WAIT;
							hs_r <= HS_IDLE;
							state_r <= S_WAIT;
						end
					end
				end
				S_WAIT: begin
					wait_r <= wait_r - 4'h1;
					if (wait_r == 4'h1)
						state_r <= S_XFER;
				end
				S_XFER: begin
					if (bus_done)
						state_r <= S_DRAIN;
					else if (sync_mode) begin
						if (!scsi_req_n) begin
							scsi_req_n <= 1'b1;
							count_r <= count_r - 24'h00_0001;
						end else if (count_r != 24'h00_0000 && outst_r < transfer_mode_reg_r[7:4] && room)
							scsi_req_n <= 1'b0;
					end else begin
						case (hs_r)
							HS_IDLE: begin
								if (count_r != 24'h00_0000 && !fifo_full) begin
									scsi_req_n <= 1'b0;
									hs_r <= HS_LOW;
								end
							end
							HS_LOW: begin
								if (!ack_s) begin
									scsi_req_n <= 1'b1;
									hs_r <= HS_HIGH;
								end
							end
							default: begin
								if (ack_rise) begin
									count_r <= count_r - 24'h00_0001;
									hs_r <= HS_IDLE;
								end
							end
						endcase
					end
				end
				default: begin
					scsi_req_n <= 1'b1;
				end
			endcase
			// Any end returns to command wait with target status
			if (end_now) begin
				state_r <= S_IDLE;
				hs_r <= HS_IDLE;
				scsi_req_n <= 1'b1;
				link_r <= `STRC_LINK_TGT;
				int_code_r <= end_code;
				int_next_r <= `STRC_INT_NONE;
				int_req <= 1'b1;
				if (end_eop)
					eop_pend_r <= 1'b1;
				if (end_code == `STRC_INT_RESET)
					rst_pend_r <= 1'b0;
			end
		end
	end

	// ********************
	// AXI4-Lite slave
	// ********************
	// Address decode for reads
	reg [31:0] rd_val;
	reg rd_bad;
	always @* begin
		rd_val = 32'h0000_0000;
		rd_bad = 1'b0;
		if (s_axi_araddr == `STRC_OFS_CMD)
			rd_val = {23'h00_0000, cmd_r};
		else if (s_axi_araddr == `STRC_OFS_BASE)
			rd_val = {8'h00, base_r};
		else if (s_axi_araddr == `STRC_OFS_CUR)
			rd_val = {8'h00, count_r};
		else if (s_axi_araddr == `STRC_OFS_TRANSFER_MODE_REG)
			rd_val = {24'h00_0000, transfer_mode_reg_r};
		else if (s_axi_araddr == `STRC_OFS_TOUT)
			rd_val = {16'h0000, tout_r};
		else if (s_axi_araddr == `STRC_OFS_EXTENDED_MODE_REG)
			rd_val = {24'h00_0000, extended_mode_reg_r};
		else if (s_axi_araddr == `STRC_OFS_STAT)
			rd_val = {16'h0000, busy ? `STRC_EXEC_CODE : 8'h00, 5'h00, busy, link_r};
		else if (s_axi_araddr == `STRC_OFS_INT)
			rd_val = {16'h0000, 7'h00, int_req, int_code_r};
		else if (s_axi_araddr == `STRC_OFS_EXTENDED_STATUS_REG)
			rd_val = {30'h0000_0000, extended_status_reg_r};
		else if (s_axi_araddr == `STRC_OFS_DATA)
			rd_val = {24'h00_0000, fifo_empty ? 8'h00 : fifo_mem[rptr_r]};
		else if (s_axi_araddr == `STRC_OFS_LINK)
			rd_val = {30'h0000_0000, link_r};
		else if (s_axi_araddr != `STRC_OFS_BRK)
			rd_bad = 1'b1;
	end

	// Write decode for the response code
	wire wr_ok = (s_axi_awaddr <= `STRC_OFS_BRK) && (s_axi_awaddr[1:0] == 2'h0) &&
		(s_axi_awaddr != `STRC_OFS_CUR) && (s_axi_awaddr != `STRC_OFS_STAT) &&
		(s_axi_awaddr != `STRC_OFS_EXTENDED_STATUS_REG) && (s_axi_awaddr != `STRC_OFS_DATA);

	// Handshakes: one write and one read in flight
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `STRC_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `STRC_RESP_OKAY;
			s_axi_rdata <= 32'h0000_0000;
		end else begin
			s_axi_awready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
			s_axi_wready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? `STRC_RESP_OKAY : `STRC_RESP_SLVERR;
			end else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
			s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_val;
				s_axi_rresp <= rd_bad ? `STRC_RESP_SLVERR : `STRC_RESP_OKAY;
			end else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

endmodule

// ### tb/strc_initiator_model.sv
// Initiator model answering each target request with one byte
`timescale 1ns/100ps
module strc_initiator_model (
	// Clock
	input wire aclk,
	// Bus pins
	input wire scsi_req_n,
	output reg [7:0] scsi_db_i,
	output reg scsi_dbp_i,
	output reg scsi_ack_n_i,
	// Bench control
	input wire [7:0] seed_byte,
	input wire [7:0] delay,
	input wire bad_par,
	output reg [7:0] sent
);
	integer i;
	// Async or sync handshake; data inverted once released
	initial begin
		scsi_ack_n_i = 1'b1;
		scsi_db_i = 8'h00;
		scsi_dbp_i = 1'b1;
		sent = 8'h00;
		forever begin
			@(posedge aclk);
			for (i = 0; i < delay && !scsi_req_n; i = i + 1)
				@(posedge aclk);
			if (!scsi_req_n) begin
				scsi_db_i <= seed_byte + sent;
				scsi_dbp_i <= ~^(seed_byte + sent) ^ bad_par;
				@(posedge aclk);
				scsi_ack_n_i <= 1'b0;
				@(posedge aclk);
				while (!scsi_req_n)
					@(posedge aclk);
				scsi_ack_n_i <= 1'b1;
				scsi_db_i <= ~scsi_db_i;
				scsi_dbp_i <= ~scsi_dbp_i;
				sent <= sent + 8'h01;
			end
		end
	end
endmodule

// ### tb/strc_receive_assertions.sv
// Checker for the target receive command block
`timescale 1ns/100ps
module strc_receive_assertions (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Register bus
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	// Bus pins and service side
	input wire scsi_req_n,
	input wire scsi_io_n,
	input wire scsi_msg_n,
	input wire scsi_cd_n,
	input wire dma_ack,
	input wire dma_req,
	input wire transfer_end_strobe,
	input wire int_req
);
	reg [7:0] since_cmd_r;
	wire cmd_take = s_axi_awvalid && s_axi_awready && s_axi_awaddr == 8'h00;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Cycles since the last command write, saturating
	always @(posedge aclk) begin
		if (!aresetn || cmd_take)
			since_cmd_r <= 8'h00;
		else if (since_cmd_r != 8'hff)
			since_cmd_r <= since_cmd_r + 8'h01;
	end
	a_phase_set: assert property (cmd_take && s_axi_wdata[5:0] == 6'h2e
		|-> ##[1:12] (!scsi_msg_n && !scsi_cd_n && scsi_io_n)) else $error("phase pins late");
	a_req_wait: assert property ($fell(scsi_req_n) |-> since_cmd_r >= 8'h08)
		else $error("request before phase wait");
	a_strobe_dma: assert property (transfer_end_strobe |-> $past(dma_ack))
		else $error("end strobe outside service");
	a_strobe_pulse: assert property (transfer_end_strobe |=> !transfer_end_strobe)
		else $error("end strobe too long");
	a_req_io: assert property (!scsi_req_n |-> scsi_io_n)
		else $error("io asserted while receiving");
	a_reset_out: assert property ($rose(aresetn) |-> scsi_req_n && !int_req && !dma_req)
		else $error("outputs active out of reset");
	a_b_after: assert property ($rose(s_axi_bvalid) |-> $past(s_axi_wready))
		else $error("write answer without transfer");
	a_r_after: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arready))
		else $error("read answer without transfer");
	a_aw_pair: assert property (s_axi_awready |-> s_axi_wready)
		else $error("address and data not taken together");
endmodule
bind strc_receive strc_receive_assertions u_chk (.*);

// ### tb/strc_receive_tb_top.sv
// Self-checking bench for the target receive command block
`timescale 1ns/100ps
`include "strc_consts.vh"
module strc_receive_tb_top;
	reg aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, rst_n, dma_ack, bad;
	integer scnt = 0;
	reg [7:0] awaddr, araddr, seed, dly, s0, tgt;
	reg [31:0] wdata;
	reg [23:0] b;
	reg [33:0] rq[$];
	reg [33:0] mq[$];
	reg [1:0] bq[$];
	wire awready, wready, bvalid, arready, rvalid, req_n, io_n, msg_n, cd_n, ack_n, dbp;
	wire dma_req, strobe, int_req;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [7:0] db, sent, dma_data;
	integer fail_count, compares, cyc, k, i;
	strc_receive uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .scsi_db_i(db), .scsi_dbp_i(dbp), .scsi_ack_n_i(ack_n),
		.scsi_rst_n_i(rst_n), .scsi_req_n(req_n), .scsi_io_n(io_n), .scsi_msg_n(msg_n),
		.scsi_cd_n(cd_n), .dma_ack(dma_ack), .dma_req(dma_req), .dma_data(dma_data),
		.transfer_end_strobe(strobe), .int_req(int_req));
	strc_initiator_model u_init (.aclk(aclk), .scsi_req_n(req_n), .scsi_db_i(db),
		.scsi_dbp_i(dbp), .scsi_ack_n_i(ack_n), .seed_byte(seed), .delay(dly),
		.bad_par(bad), .sent(sent));
	// Clock
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	task chk(input [33:0] seen, input [33:0] exp);
		begin
			compares = compares + 1;
			if (seen !== exp) begin
				fail_count = fail_count + 1;
				$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	task results;
		begin
			$display("compares=%0d fail_count=%0d", compares, fail_count);
			if (fail_count == 0 && compares > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	// Response monitor, end strobe catcher and watchdog
	always @(posedge aclk) begin
		if (bvalid && bready)
			chk({32'h0000_0000, bresp}, {32'h0000_0000, bq.pop_front()});
		if (rvalid && rready)
			chk({rresp, rdata} & mq.pop_front(), rq.pop_front());
		if (strobe)
			scnt = scnt + 1;
		cyc = cyc + 1;
		if (cyc == 60000) begin
			fail_count = fail_count + 1;
			results;
		end
	end
	task wr(input [7:0] a, input [31:0] d, input [1:0] e);
		reg ta, tw;
		begin
			bq.push_back(e);
			ta = 1'b0;
			tw = 1'b0;
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			while (!(ta && tw)) begin
				@(posedge aclk);
				if (awready) begin
					ta = 1'b1;
					awvalid <= 1'b0;
				end
				if (wready) begin
					tw = 1'b1;
					wvalid <= 1'b0;
				end
			end
			while (!bvalid)
				@(posedge aclk);
			bready <= 1'b0;
			@(posedge aclk);
		end
	endtask
	task rd(input [7:0] a, input [33:0] e, input [33:0] m);
		begin
			rq.push_back(e & m);
			mq.push_back(m);
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
			@(posedge aclk);
			while (!arready)
				@(posedge aclk);
			arvalid <= 1'b0;
			while (!rvalid)
				@(posedge aclk);
			rready <= 1'b0;
			@(posedge aclk);
		end
	endtask
	function [8:0] op(input [1:0] s, input [1:0] p);
		op = {~^{s, 3'b101, p, 1'b0}, s, 3'b101, p, 1'b0};
	endfunction
	// Wait for the request, check the cause, then clear it
	task intchk(input [7:0] c);
		begin
			while (!int_req)
				@(posedge aclk);
			rd(`STRC_OFS_INT, {26'h000_0001, c}, 34'h0_0000_01ff);
			wr(`STRC_OFS_INT, 32'h0000_0000, `STRC_RESP_OKAY);
		end
	endtask
	task eop;
		integer s_b;
		begin
			s_b = scnt;
			dma_ack <= 1'b1;
			repeat (3) @(posedge aclk);
			dma_ack <= 1'b0;
			@(posedge aclk);
			chk(scnt - s_b, 34'h1);
		end
	endtask
	// Main sequence
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, dma_ack, bad} = 8'h00;
		rst_n = 1'b1;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0000_0000;
		fail_count = 0;
		compares = 0;
		cyc = 0;
		k = $urandom(44);
		seed = $urandom;
		dly = 8'h00;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(`STRC_OFS_STAT, 34'h0, 34'h3);
		for (k = 0; k < 2; k = k + 1) begin
			wr(`STRC_OFS_LINK, k, `STRC_RESP_OKAY);
			wr(`STRC_OFS_CMD, op(0, 0), `STRC_RESP_OKAY);
			intchk(`STRC_INT_INVALID);
			rd(`STRC_OFS_STAT, 34'h2, 34'h3);
		end
		wr(`STRC_OFS_CMD, op(0, 0) ^ 9'h100, `STRC_RESP_OKAY);
		intchk(`STRC_INT_CPAR);
		eop;
		wr(`STRC_OFS_CMD, op(0, 2), `STRC_RESP_OKAY);
		intchk(`STRC_INT_INVALID);
		rd(8'h40, {`STRC_RESP_SLVERR, 32'h0000_0000}, 34'h3_ffff_ffff);
		wr(`STRC_OFS_CUR, 32'h0000_0000, `STRC_RESP_SLVERR);
		rst_n <= 1'b0;
		repeat (4) @(posedge aclk);
		rst_n <= 1'b1;
		repeat (4) @(posedge aclk);
		wr(`STRC_OFS_CMD, op(0, 0), `STRC_RESP_OKAY);
		intchk(`STRC_INT_RESET);
		intchk(`STRC_INT_INVALID);
		// Counter load modes and phases, each ended by a break
		dly = 8'd200;
		for (k = 0; k < 4; k = k + 1) begin
			b = $urandom | 24'h00_0101;
			wr(`STRC_OFS_BASE, {8'h00, b}, `STRC_RESP_OKAY);
			wr(`STRC_OFS_CMD, op(k, k[1] ? 2'd3 : k), `STRC_RESP_OKAY);
			repeat (12) @(posedge aclk);
			chk({msg_n, cd_n, io_n}, k[1] ? 3'b001 : k ? 3'b101 : 3'b111);
			rd(`STRC_OFS_CUR, {10'h000, k == 0 ? b : k == 1 ? {b[23:8], 8'h00} :
				k == 2 ? {16'h0000, b[7:0]} : 24'h00_0001}, 34'h0_00ff_ffff);
			rd(`STRC_OFS_STAT, 34'h5104, 34'hff04);
			wr(`STRC_OFS_BRK, 32'h0000_0001, `STRC_RESP_OKAY);
			intchk(`STRC_INT_BREAK);
			eop;
		end
		wr(`STRC_OFS_CMD, op(3, 0), `STRC_RESP_OKAY);
		rd(`STRC_OFS_DATA, 34'h0, 34'h0);
		intchk(`STRC_INT_OVUN);
		eop;
		dly = 8'd60;
		wr(`STRC_OFS_TOUT, 32'h0000_0014, `STRC_RESP_OKAY);
		wr(`STRC_OFS_CMD, op(3, 1), `STRC_RESP_OKAY);
		intchk(`STRC_INT_TOUT);
		eop;
		wr(`STRC_OFS_TOUT, 32'h0000_0000, `STRC_RESP_OKAY);
		// Four five-byte receptions: clean, parity continued with DMA drain,
		// parity abort, clean in synchronous mode with offset one
		for (k = 0; k < 4; k = k + 1) begin
			dly = (k == 3) ? 8'h00 : $urandom % 4;
			bad <= (k == 1 || k == 2);
			wr(`STRC_OFS_EXTENDED_MODE_REG, k == 1, `STRC_RESP_OKAY);
			wr(`STRC_OFS_TRANSFER_MODE_REG, (k == 3) ? 32'h0000_0010 : 32'h0000_0000, `STRC_RESP_OKAY);
			wr(`STRC_OFS_BASE, 32'h0000_0005, `STRC_RESP_OKAY);
			s0 = sent;
			tgt = s0 + 8'h05;
			wr(`STRC_OFS_CMD, op(2, 0), `STRC_RESP_OKAY);
			if (k != 2) begin
				while (sent != tgt)
					@(posedge aclk);
				for (i = 0; i < 5; i = i + 1) begin
					if (k == 1) begin
						@(posedge aclk);
						chk({33'h0_0000_0000, dma_req}, 34'h1);
						dma_ack <= 1'b1;
						@(posedge aclk);
						dma_ack <= 1'b0;
						@(posedge aclk);
						chk({26'h000_0000, dma_data}, {26'h000_0000, seed + s0});
					end else
						rd(`STRC_OFS_DATA, {26'h000_0000, seed + s0}, 34'hff);
					s0 = s0 + 8'h01;
				end
				rd(`STRC_OFS_CUR, 34'h0, 34'h0_00ff_ffff);
				intchk(`STRC_INT_NORMAL);
				rd(`STRC_OFS_EXTENDED_STATUS_REG, k == 1, 34'h1);
			end else begin
				intchk(`STRC_INT_SPAR);
				eop;
			end
		end
		results;
	end
endmodule
